// ### hw/alu_cfg.svh
// Summary of operation
// - pointer operand fetches word at pointed address
// - pointer value used as hex address
// - word load fills low half, clears upper
// - double load fills all 32 bits
// - out-of-range address sets range error flag
// - negative flag follows sign of each loaded value
// - zero flag set when zero loaded
// - back-to-back loads push old accumulator
// - bit-field load copies run from bit 0
// - bits above count become zero
// - octal operand converted to binary, loaded
// - indexed address is source plus stack level
// - indexed offset hex, low half loaded
// - eight deep stack, deepest entry lost
// - accumulator cleared at scan end
// - store cancels the pending push
`ifndef ALU_CFG_SVH
`define ALU_CFG_SVH
`define ALU_STACK_DEPTH 8
`define ALU_ACC_W 32
`define ALU_WORD_W 16
`define ALU_BITCNT_W 6
`define ALU_MAX_BITS 6'h20
`define ALU_OCT_DIGITS 6
`define ALU_REG_AW 8
// register byte offsets
`define ALU_REG_LIMIT 8'h00
`define ALU_REG_ACC 8'h04
`define ALU_REG_STK0 8'h08
`define ALU_REG_FLAGS 8'h0c
`define ALU_REG_STAT 8'h10
`define ALU_REG_CLR 8'h14
`define ALU_REG_EN 8'h18
// reset values
`define ALU_LIMIT_RST 16'h3fff
`define ALU_EN_RST 2'h0
// interrupt status bit positions
`define ALU_EV_DONE 0
`define ALU_EV_RANGE 1
`define ALU_EV_W 2
`endif

// ### hw/alu_pkg.sv
package alu_pkg;
  typedef enum logic [2:0] {
    ALU_OP_WORD = 3'h0,
    ALU_OP_DWORD = 3'h1,
    ALU_OP_FIELD = 3'h2,
    ALU_OP_OCTAL = 3'h3,
    ALU_OP_INDEX = 3'h4,
    ALU_OP_STORE = 3'h5,
    ALU_OP_SCAN_END = 3'h6,
    ALU_OP_NOP = 3'h7
  } alu_op_t;
  typedef enum logic [1:0] {
    ALU_SRC_MEM = 2'h0,
    ALU_SRC_PTR = 2'h1,
    ALU_SRC_CONST = 2'h2,
    ALU_SRC_RSVD = 2'h3
  } alu_src_t;
  typedef enum logic [2:0] {
    ALU_ST_IDLE = 3'h0,
    ALU_ST_PTR = 3'h1,
    ALU_ST_ADDR = 3'h2,
    ALU_ST_LO = 3'h3,
    ALU_ST_HI = 3'h4,
    ALU_ST_BITS = 3'h5,
    ALU_ST_COMMIT = 3'h6
  } alu_state_t;
endpackage

// ### hw/alu_load_unit.sv
// Implementation choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "alu_cfg.svh"
module alu_load_unit (
  input wire logic clk,
  input wire logic resetn,
  // instruction port from the sequencer
  input wire logic cmd_valid,
  input wire alu_pkg::alu_op_t cmd_op,
  input wire alu_pkg::alu_src_t cmd_src,
  input wire logic [15:0] cmd_addr,
  input wire logic [31:0] cmd_const,
  input wire logic [5:0] cmd_count,
  output logic cmd_ready,
  output logic load_done,
  // word memory, data one cycle after the read strobe
  output logic mem_rd,
  output logic [15:0] mem_addr,
  input wire logic [15:0] mem_rdata,
  // discrete bit memory, data one cycle after the read strobe
  output logic bit_rd,
  output logic [15:0] bit_addr,
  input wire logic bit_rdata,
  // accumulator and flags
  output logic [31:0] acc,
  output logic pointer_range_error_flag,
  output logic negative_flag,
  output logic zero_flag,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic irq
);
  import alu_pkg::*;

  alu_state_t state_q;
  alu_op_t op_q;
  logic [31:0] stk_q [`ALU_STACK_DEPTH];
  logic [31:0] acc_q, res_q, rdata_q;
  logic [15:0] base_q, ea_q, limit_q, mem_addr_q, bit_addr_q;
  logic [5:0] cnt_q, idx_q;
  logic chain_q, err_q, done_q, ready_q, mem_rd_q, bit_rd_q;
  logic perr_q, neg_q, zero_q, irq_q;
  logic [`ALU_EV_W-1:0] stat_q, en_q;

  // octal digits arrive one per nibble; each keeps its low three bits
  function automatic logic [15:0] oct_to_bin(input logic [31:0] d);
    logic [17:0] v;
    v = '0;
    for (int i = 0; i < `ALU_OCT_DIGITS; i++) begin
      v[i*3 +: 3] = d[i*4 +: 3];
    end
    return v[15:0];
  endfunction

  // address arithmetic, done 17 bits wide so a carry counts as out of range
  wire logic [15:0] offset = chain_q ? acc_q[15:0] : stk_q[0][15:0];
  wire logic [16:0] ea_sum = {1'b0, base_q} + {1'b0, offset};
  wire logic [16:0] ea_calc = (op_q == ALU_OP_INDEX) ? ea_sum : {1'b0, base_q};
  wire logic [16:0] ea_last = (op_q == ALU_OP_DWORD) ? ea_calc + 17'h1 : ea_calc;
  wire logic ea_bad = ea_last > {1'b0, limit_q};
  wire logic accept = cmd_valid && ready_q;
  wire logic is_load = (cmd_op != ALU_OP_STORE) && (cmd_op != ALU_OP_SCAN_END) &&
                       (cmd_op != ALU_OP_NOP);
  wire logic commit_ok = (state_q == ALU_ST_COMMIT) && !err_q;
  wire logic commit_err = (state_q == ALU_ST_COMMIT) && err_q;
  wire logic scan_end = accept && (cmd_op == ALU_OP_SCAN_END);
  wire logic [5:0] idx_next = idx_q + 6'h1;

  // register decode
  wire logic wr_limit = reg_wr && (reg_addr == `ALU_REG_LIMIT);
  wire logic wr_clr = reg_wr && (reg_addr == `ALU_REG_CLR);
  wire logic wr_en = reg_wr && (reg_addr == `ALU_REG_EN);
  wire logic [`ALU_EV_W-1:0] ev_set = {commit_err, state_q == ALU_ST_COMMIT};
  wire logic [`ALU_EV_W-1:0] clr_bits = wr_clr ? reg_wdata[`ALU_EV_W-1:0] : '0;
  // next status and enable, shared by the status and interrupt flops
  wire logic [`ALU_EV_W-1:0] stat_next = (stat_q & ~clr_bits) | ev_set;
  wire logic [`ALU_EV_W-1:0] en_next = wr_en ? reg_wdata[`ALU_EV_W-1:0] : en_q;
  wire logic [31:0] rd_mux =
    (reg_addr == `ALU_REG_LIMIT) ? {16'h0, limit_q} :
    (reg_addr == `ALU_REG_ACC) ? acc_q :
    (reg_addr == `ALU_REG_STK0) ? stk_q[0] :
    (reg_addr == `ALU_REG_FLAGS) ? {29'h0, zero_q, neg_q, perr_q} :
    (reg_addr == `ALU_REG_STAT) ? {30'h0, stat_q} :
    (reg_addr == `ALU_REG_EN) ? {30'h0, en_q} : 32'h0;

  // sequencing of one instruction; memory strobes are single-cycle pulses
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= ALU_ST_IDLE;
      op_q <= ALU_OP_NOP;
      res_q <= 32'h0;
      base_q <= 16'h0;
      ea_q <= 16'h0;
      cnt_q <= 6'h0;
      idx_q <= 6'h0;
      err_q <= 1'b0;
      mem_rd_q <= 1'b0;
      mem_addr_q <= 16'h0;
      bit_rd_q <= 1'b0;
      bit_addr_q <= 16'h0;
    end else begin
      mem_rd_q <= 1'b0;
      bit_rd_q <= 1'b0;
      case (state_q)
        ALU_ST_IDLE: begin
          if (accept && is_load) begin
            op_q <= cmd_op;
            err_q <= 1'b0;
            res_q <= 32'h0;
            base_q <= cmd_addr;
            cnt_q <= (cmd_count > `ALU_MAX_BITS) ? `ALU_MAX_BITS : cmd_count;
            idx_q <= 6'h0;
            if (cmd_op == ALU_OP_OCTAL) begin
              res_q <= {16'h0, oct_to_bin(cmd_const)};
              state_q <= ALU_ST_COMMIT;
            end else if (cmd_op == ALU_OP_FIELD) begin
              bit_rd_q <= (cmd_count != 6'h0);
              bit_addr_q <= cmd_addr;
              state_q <= (cmd_count != 6'h0) ? ALU_ST_BITS : ALU_ST_COMMIT;
            end else if (cmd_src == ALU_SRC_CONST && cmd_op != ALU_OP_INDEX) begin
              res_q <= (cmd_op == ALU_OP_DWORD) ? cmd_const :
                       {16'h0, cmd_const[15:0]};
              state_q <= ALU_ST_COMMIT;
            end else if (cmd_src == ALU_SRC_PTR) begin
              mem_rd_q <= 1'b1;
              mem_addr_q <= cmd_addr;
              state_q <= ALU_ST_PTR;
            end else begin
              state_q <= ALU_ST_ADDR;
            end
          end
        end
        ALU_ST_PTR: begin
          if (!mem_rd_q) begin
            base_q <= mem_rdata;
            state_q <= ALU_ST_ADDR;
          end
        end
        ALU_ST_ADDR: begin
          ea_q <= ea_calc[15:0];
          // a bad address skips the fetch, so no undefined word reaches the result
          if (ea_bad) begin
            err_q <= 1'b1;
            state_q <= ALU_ST_COMMIT;
          end else begin
            mem_rd_q <= 1'b1;
            mem_addr_q <= ea_calc[15:0];
            state_q <= ALU_ST_LO;
          end
        end
        ALU_ST_LO: begin
          if (!mem_rd_q) begin
            res_q <= {16'h0, mem_rdata};
            if (op_q == ALU_OP_DWORD) begin
              mem_rd_q <= 1'b1;
              mem_addr_q <= ea_q + 16'h1;
              state_q <= ALU_ST_HI;
            end else begin
              state_q <= ALU_ST_COMMIT;
            end
          end
        end
        ALU_ST_HI: begin
          if (!mem_rd_q) begin
            res_q[31:16] <= mem_rdata;
            state_q <= ALU_ST_COMMIT;
          end
        end
        ALU_ST_BITS: begin
          // the count was clamped on entry, so idx_next always meets cnt_q
          if (!bit_rd_q) begin
            res_q[idx_q[4:0]] <= bit_rdata;
            idx_q <= idx_next;
            if (idx_next == cnt_q) begin
              state_q <= ALU_ST_COMMIT;
            end else begin
              bit_rd_q <= 1'b1;
              bit_addr_q <= bit_addr_q + 16'h1;
            end
          end
        end
        ALU_ST_COMMIT: begin
          state_q <= ALU_ST_IDLE;
        end
        default: begin
          state_q <= ALU_ST_IDLE;
        end
      endcase
    end
  end

  // handshake: ready only while idle, done for one cycle after a commit or a non-load command
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ready_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      ready_q <= (state_q == ALU_ST_IDLE) ? !(accept && is_load) :
                 (state_q == ALU_ST_COMMIT);
      done_q <= (state_q == ALU_ST_COMMIT) || (accept && !is_load);
    end
  end

  // accumulator, chain tracking and flags; an error commits no data
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      acc_q <= 32'h0;
      chain_q <= 1'b0;
      perr_q <= 1'b0;
      neg_q <= 1'b0;
      zero_q <= 1'b0;
    end else if (scan_end) begin
      // store and scan end are taken only while idle, never beside a commit
      acc_q <= 32'h0;
      chain_q <= 1'b0;
    end else if (accept && cmd_op == ALU_OP_STORE) begin
      chain_q <= 1'b0;
    end else if (commit_err) begin
      perr_q <= 1'b1;
    end else if (commit_ok) begin
      acc_q <= res_q;
      chain_q <= 1'b1;
      perr_q <= 1'b0;
      neg_q <= res_q[31];
      zero_q <= (res_q == 32'h0);
    end
  end

  // stack shifts down on push; the eighth entry simply falls off
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < `ALU_STACK_DEPTH; i++) begin
        stk_q[i] <= 32'h0;
      end
    end else if (commit_ok && chain_q) begin
      stk_q[0] <= acc_q;
      for (int i = 1; i < `ALU_STACK_DEPTH; i++) begin
        stk_q[i] <= stk_q[i-1];
      end
    end
  end

  // software settings; the limit bounds every computed word address
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      limit_q <= `ALU_LIMIT_RST;
      en_q <= `ALU_EN_RST;
    end else begin
      if (wr_limit) begin
        limit_q <= reg_wdata[15:0];
      end
      if (wr_en) begin
        en_q <= reg_wdata[`ALU_EV_W-1:0];
      end
    end
  end

  // sticky status; a new event wins over a clear in the same cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stat_q <= '0;
    end else begin
      stat_q <= stat_next;
    end
  end

  // read data stands for one cycle only and reads zero otherwise
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= 32'h0;
    end else begin
      rdata_q <= reg_rd ? rd_mux : 32'h0;
    end
  end

  // built from next status and enable, so the line rises with the event
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(stat_next & en_next);
    end
  end

  // every output comes straight from a register
  assign cmd_ready = ready_q;
  assign load_done = done_q;
  assign mem_rd = mem_rd_q;
  assign mem_addr = mem_addr_q;
  assign bit_rd = bit_rd_q;
  assign bit_addr = bit_addr_q;
  assign acc = acc_q;
  assign pointer_range_error_flag = perr_q;
  assign negative_flag = neg_q;
  assign zero_flag = zero_q;
  assign reg_rdata = rdata_q;
  assign irq = irq_q;
endmodule
`default_nettype wire

// ### dv/alu_load_unit_properties.sv
`timescale 1ns/1ps
`default_nettype none
module alu_load_unit_chk (
  input wire logic clk,
  input wire logic resetn,
  input wire logic cmd_valid,
  input wire alu_pkg::alu_op_t cmd_op,
  input wire logic [5:0] cmd_count,
  input wire logic cmd_ready,
  input wire logic load_done,
  input wire logic [31:0] acc,
  input wire logic pointer_range_error_flag,
  input wire logic negative_flag,
  input wire logic zero_flag
);
  import alu_pkg::*;
  alu_op_t op_q;
  logic [5:0] cnt_q;
  // a taken command and a good load at its done
  wire take = cmd_valid && cmd_ready;
  wire ld = load_done && op_q < ALU_OP_STORE;
  wire ok = ld && !pointer_range_error_flag;
  // the ports no longer show the op at done, so keep it
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      op_q <= ALU_OP_NOP;
      cnt_q <= 6'h0;
    end else if (take) begin
      op_q <= cmd_op;
      cnt_q <= cmd_count;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  a_done_pulse: assert property (load_done && !take |=> !load_done)
    else $error("done too long");
  a_busy_then_done: assert property (take && cmd_op < ALU_OP_STORE |=>
    !cmd_ready ##[0:99] load_done) else $error("no done");
  a_nonload_done: assert property (take && cmd_op >= ALU_OP_STORE |=>
    load_done && cmd_ready) else $error("no done for non-load");
  a_ready_at_done: assert property (load_done |-> cmd_ready)
    else $error("not ready at done");
  a_upper_clear: assert property (ok && op_q inside {ALU_OP_WORD, ALU_OP_OCTAL,
    ALU_OP_INDEX} |-> acc[31:16] == 16'h0) else $error("upper half set");
  a_neg_sign: assert property (ok |-> negative_flag == acc[31])
    else $error("bad negative");
  a_zero_val: assert property (ok |-> zero_flag == (acc == 32'h0))
    else $error("bad zero");
  a_err_hold: assert property (ld && pointer_range_error_flag |-> $stable(acc))
    else $error("acc moved on error");
  a_scan_clear: assert property (load_done && op_q == ALU_OP_SCAN_END |-> acc == 32'h0)
    else $error("acc kept at scan end");
  a_field_top: assert property (ok && op_q == ALU_OP_FIELD && cnt_q < 6'h20
    |-> (acc >> cnt_q) == 32'h0) else $error("field top set");
endmodule
bind alu_load_unit alu_load_unit_chk alu_load_unit_chk_inst (.*);
`default_nettype wire

// ### dv/alu_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module alu_mem_model (
  input wire logic clk,
  input wire logic mem_rd,
  input wire logic [15:0] mem_addr,
  output logic [15:0] mem_rdata = 16'h0,
  input wire logic bit_rd,
  input wire logic [15:0] bit_addr,
  output logic bit_rdata = 1'b0
);
  logic [15:0] mem [256];
  logic bits [256];
  // data only in the cycle after the strobe, flipped otherwise to catch late use
  always_ff @(posedge clk) begin
    mem_rdata <= mem_rd ? mem[mem_addr[7:0]] : ~mem_rdata;
    bit_rdata <= bit_rd ? bits[bit_addr[7:0]] : ~bit_rdata;
  end
endmodule
`default_nettype wire

// ### dv/tb_alu_load_unit.sv
`timescale 1ns/1ps
`default_nettype none
`include "alu_cfg.svh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin failures++; \
  $display("CHECK FAILED %0t %h %h", $time, a, b); end end
module tb_alu_load_unit;
  import alu_pkg::*;
  logic clk, resetn, cmd_valid, cmd_ready, load_done, mem_rd, bit_rd, bit_rdata, irq;
  logic pointer_range_error_flag, negative_flag, zero_flag, reg_wr, reg_rd;
  alu_op_t cmd_op, op;
  alu_src_t cmd_src, src;
  logic [15:0] cmd_addr, mem_addr, mem_rdata, bit_addr, lim_m;
  logic [31:0] cmd_const, acc, reg_wdata, reg_rdata, acc_m, q, r;
  logic [5:0] cmd_count;
  logic [7:0] reg_addr;
  logic err_m, neg_m, zero_m, pend;
  logic [31:0] stk [$];
  int failures, n_compared, i;
  alu_load_unit alu_load_unit_inst (.*);
  alu_mem_model alu_mem_model_inst (.*);
  // free running bench clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic end_of_test();
    if (failures == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // one register strobe, then the answer one cycle later
  task automatic rw(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= wr;
    reg_rd <= !wr;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    @(posedge clk);
    q = reg_rdata;
  endtask
  function automatic logic [15:0] mw(input logic [16:0] x);
    return alu_mem_model_inst.mem[x[7:0]];
  endfunction
  // issue one command, run the reference model, compare accumulator, flags and stack top
  task automatic run(input alu_op_t o, input alu_src_t s, input logic [15:0] a,
                     input logic [31:0] c, input logic [5:0] n);
    logic [16:0] ea;
    logic [31:0] v;
    logic e;
    int k;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_op <= o;
    cmd_src <= s;
    cmd_addr <= a;
    cmd_const <= c;
    cmd_count <= n;
    do @(posedge clk); while (cmd_ready !== 1'b1);
    cmd_valid <= 1'b0;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (load_done !== 1'b1 && k < 200);
    if (k >= 200) failures++;
    ea = {1'b0, a};
    if (s == ALU_SRC_PTR && (o < ALU_OP_FIELD || o == ALU_OP_INDEX))
      ea = {1'b0, mw(ea)};
    if (o == ALU_OP_INDEX)
      ea = ea + (pend ? acc_m[15:0] : stk.size() ? stk[0][15:0] : 16'h0);
    e = (o == ALU_OP_INDEX || (o < ALU_OP_FIELD && s != ALU_SRC_CONST))
        && ea + (o == ALU_OP_DWORD) > {1'b0, lim_m};
    v = {mw(ea + 1), mw(ea)};
    if (o != ALU_OP_DWORD) v[31:16] = 16'h0;
    if (s == ALU_SRC_CONST && o < ALU_OP_FIELD) v = o == ALU_OP_DWORD ? c : c[15:0];
    if (o == ALU_OP_FIELD) for (k = 0; k < 32; k++) v[k] = k < n &&
        alu_mem_model_inst.bits[8'(a + k)];
    if (o == ALU_OP_OCTAL) v = 0;
    if (o == ALU_OP_OCTAL) for (k = 5; k >= 0; k--) v = 16'(v * 8 + c[4 * k +: 3]);
    if (o == ALU_OP_STORE || o == ALU_OP_SCAN_END) pend = 1'b0;
    if (o == ALU_OP_SCAN_END) acc_m = 32'h0;
    if (o < ALU_OP_STORE && e) err_m = 1'b1;
    if (o < ALU_OP_STORE && !e) begin
      if (pend) stk.push_front(acc_m);
      if (stk.size() > 8) void'(stk.pop_back());
      {acc_m, err_m, neg_m, zero_m, pend} = {v, 1'b0, v[31], v == 0, 1'b1};
    end
    `CHK(acc, acc_m)
    `CHK(pointer_range_error_flag, err_m)
    `CHK(negative_flag, neg_m)
    `CHK(zero_flag, zero_m)
    rw(1'b0, `ALU_REG_STK0, 32'h0);
    `CHK(q, stk.size() ? stk[0] : 32'h0)
  endtask
  initial begin
    #5000000;
    failures++;
    end_of_test();
  end
  initial begin
    {resetn, cmd_valid, cmd_addr, cmd_const, cmd_count} = 0;
    {reg_addr, reg_wdata, reg_wr, reg_rd, acc_m, err_m, neg_m, zero_m, pend} = 0;
    cmd_op = ALU_OP_NOP;
    cmd_src = ALU_SRC_MEM;
    lim_m = `ALU_LIMIT_RST;
    void'($urandom(32'h16141816));
    for (i = 0; i < 256; i++) begin
      r = $urandom;
      alu_mem_model_inst.mem[i] = r[15:0] & 16'h40ff;
      alu_mem_model_inst.bits[i] = r[16];
    end
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    rw(1'b0, `ALU_REG_LIMIT, 32'h0);
    `CHK(q, 32'h3fff)
    rw(1'b0, 8'h1c, 32'h0);
    `CHK(q, 32'h0)
    run(ALU_OP_WORD, ALU_SRC_CONST, 16'h0, 32'h0, 6'h0);
    for (i = 0; i < 60; i++) begin
      r = $urandom;
      op = alu_op_t'(r[2:0]);
      src = alu_src_t'(r[4:3] % 2'd3);
      if (i == 30) rw(1'b1, `ALU_REG_LIMIT, 32'h80);
      if (i == 30) lim_m = 16'h80;
      run(op, src, (src == ALU_SRC_PTR || op == ALU_OP_INDEX) ? {8'h0, r[23:16]} :
          r[31:16] & 16'h40ff, $urandom, {1'b0, r[9:5]} + 6'h1);
    end
    run(ALU_OP_WORD, ALU_SRC_MEM, 16'h0080, 32'h0, 6'h0);
    run(ALU_OP_DWORD, ALU_SRC_MEM, 16'h0080, 32'h0, 6'h0);
    run(ALU_OP_OCTAL, ALU_SRC_MEM, 16'h0, 32'h040400, 6'h0);
    `CHK(acc, 32'h4100)
    rw(1'b1, `ALU_REG_CLR, 32'h3);
    rw(1'b1, `ALU_REG_EN, 32'h1);
    `CHK(irq, 1'b0)
    run(ALU_OP_WORD, ALU_SRC_CONST, 16'h0, 32'h8000, 6'h0);
    `CHK(irq, 1'b1)
    rw(1'b1, `ALU_REG_EN, 32'h0);
    rw(1'b0, `ALU_REG_STAT, 32'h0);
    `CHK(q, 32'h1)
    `CHK(irq, 1'b0)
    end_of_test();
  end
endmodule
`default_nettype wire
